/* verilog/audio_slot_map_config.sv */
// Slot assignment registers for capture channels 2 to 4 and the first
// master configuration register, with decoded placement and clock controls.
// Assumes register port and slot timing signals come from logic on i_clk; only the
// generated bit clock and frame sync inputs are synchronised here before use.
`timescale 1ns/1ps
`default_nettype none

module audio_slot_map_config (
  // Clock and reset
  input  wire logic        i_clk,
  input  wire logic        i_nrst,
  input  wire logic        i_ce,
  // Register port
  input  wire logic        i_reg_wr,
  input  wire logic        i_reg_rd,
  input  wire logic [7:0]  i_reg_addr,
  input  wire logic [7:0]  i_reg_wdata,
  output logic      [7:0]  o_reg_rdata,
  // Link side
  input  wire logic        i_tdm_mode,
  input  wire logic [5:0]  i_cur_slot,
  input  wire logic        i_cur_right,
  input  wire logic        i_bclk_gen,
  input  wire logic        i_frame_sync_gen,
  input  wire logic [2:0]  i_chan_enable,
  // Outputs
  output logic             o_bclk,
  output logic             o_bclk_oe,
  output logic             o_frame_sync,
  output logic             o_frame_sync_oe,
  output logic             o_custom_clk_cfg,
  output logic             o_pll_enable,
  output logic             o_rate_family,
  output logic      [15:0] o_ref_clock_khz,
  output logic      [2:0]  o_slot_talk
);

  logic [5:0]                        chan_slot_reg [3];  // Slot numbers, channels 2 to 4
  logic [7:0]                        master_cfg_reg;     // Master configuration
  audio_slot_map_pkg::master_cfg_s   cfg;                // Field view
  audio_slot_map_pkg::slot_place_s   place [3];          // Decoded placements
  logic [1:0]                        gen_meta_reg;       // First sync stage, bit clock then frame sync
  logic [1:0]                        gen_sync_reg;       // Second sync stage, only stage read by logic
  logic [7:0]                        rdata_next;         // Read mux result
  logic [2:0]                        talk_next;          // Slot match result

  assign cfg = master_cfg_reg;

  // Slot registers; reserved bits are never stored
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      chan_slot_reg[0] <= audio_slot_map_pkg::CHAN2_SLOT_RESET;
      chan_slot_reg[1] <= audio_slot_map_pkg::CHAN3_SLOT_RESET;
      chan_slot_reg[2] <= audio_slot_map_pkg::CHAN4_SLOT_RESET;
    end else if (i_ce && i_reg_wr) begin
      // Only bits 5:0 are kept, so a stray write to 7:6 is harmless
      case (i_reg_addr)
        audio_slot_map_pkg::CHAN2_SLOT_SELECT_ADDR: chan_slot_reg[0] <= i_reg_wdata[5:0];
        audio_slot_map_pkg::CHAN3_SLOT_SELECT_ADDR: chan_slot_reg[1] <= i_reg_wdata[5:0];
        audio_slot_map_pkg::CHAN4_SLOT_SELECT_ADDR: chan_slot_reg[2] <= i_reg_wdata[5:0];
        default: begin
        end
      endcase
    end
  end

  // Master configuration register, all eight bits writable
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      master_cfg_reg <= audio_slot_map_pkg::MASTER_CFG_RESET;
    end else if (i_ce && i_reg_wr && i_reg_addr == audio_slot_map_pkg::PORT_MASTER_CONFIG_A_ADDR) begin
      master_cfg_reg <= i_reg_wdata;
    end
  end

  // Read mux; unmapped addresses read zero
  always_comb begin
    rdata_next = 8'h00;
    case (i_reg_addr)
      audio_slot_map_pkg::CHAN2_SLOT_SELECT_ADDR:    rdata_next = {2'b00, chan_slot_reg[0]};
      audio_slot_map_pkg::CHAN3_SLOT_SELECT_ADDR:    rdata_next = {2'b00, chan_slot_reg[1]};
      audio_slot_map_pkg::CHAN4_SLOT_SELECT_ADDR:    rdata_next = {2'b00, chan_slot_reg[2]};
      audio_slot_map_pkg::PORT_MASTER_CONFIG_A_ADDR: rdata_next = master_cfg_reg;
      default:                                       rdata_next = 8'h00;
    endcase
  end

  // Registered read data, updated on a read strobe
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_reg_rdata <= 8'h00;
    end else if (i_ce && i_reg_rd) begin
      o_reg_rdata <= rdata_next;
    end
  end

  // Slot decode: top bit picks the half, low five bits the slot in it
  for (genvar g = 0; g < 3; g++) begin : g_place
    assign place[g].tdm_slot   = chan_slot_reg[g];
    assign place[g].right_half = chan_slot_reg[g] >= audio_slot_map_pkg::RIGHT_HALF_BASE;
    assign place[g].half_slot  = chan_slot_reg[g][4:0];
  end

  // Talk enable per channel: true only in the selected slot
  always_comb begin
    talk_next = 3'b000;
    for (int k = 0; k < 3; k++) begin
      if (i_tdm_mode) begin
        talk_next[k] = i_chan_enable[k] && (i_cur_slot == place[k].tdm_slot);
      end else begin
        talk_next[k] = i_chan_enable[k] && (i_cur_right == place[k].right_half)
                       && (i_cur_slot[4:0] == place[k].half_slot);
      end
    end
  end

  // Slot talk strobes registered so outputs come from flops
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_slot_talk <= 3'b000;
    end else if (i_ce) begin
      o_slot_talk <= talk_next;
    end
  end

  // Two-stage sync of the generated clock waveforms, which come from another domain
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      gen_meta_reg <= 2'b00;
      gen_sync_reg <= 2'b00;
    end else if (i_ce) begin
      gen_meta_reg <= {i_bclk_gen, i_frame_sync_gen};
      gen_sync_reg <= gen_meta_reg;
    end
  end

  // Clock pin drive: slave leaves pins undriven, master always drives them, low while gated
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_bclk          <= 1'b0;
      o_frame_sync    <= 1'b0;
      o_bclk_oe       <= 1'b0;
      o_frame_sync_oe <= 1'b0;
    end else if (i_ce) begin
      o_bclk_oe       <= cfg.master_slave_select;
      o_frame_sync_oe <= cfg.master_slave_select;
      // Gating holds the pins low rather than floating them, so the far
      // side sees a clean idle level
      o_bclk       <= cfg.master_slave_select && !cfg.port_clock_gate && gen_sync_reg[1];
      o_frame_sync <= cfg.master_slave_select && !cfg.port_clock_gate && gen_sync_reg[0];
    end
  end

  // Clock configuration outputs
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_custom_clk_cfg <= 1'b0;
      o_pll_enable     <= 1'b1;
      o_rate_family    <= 1'b0;
      o_ref_clock_khz  <= audio_slot_map_pkg::REF_KHZ_2;
    end else if (i_ce) begin
      o_custom_clk_cfg <= cfg.auto_cfg_custom;
      // PLL disable only has meaning while the settings are derived
      o_pll_enable     <= cfg.auto_cfg_custom || !cfg.auto_pll_disable;
      o_rate_family    <= cfg.rate_family_select;
      case (cfg.ref_clock_freq_select)
        3'h0:    o_ref_clock_khz <= audio_slot_map_pkg::REF_KHZ_0;
        3'h1:    o_ref_clock_khz <= audio_slot_map_pkg::REF_KHZ_1;
        3'h2:    o_ref_clock_khz <= audio_slot_map_pkg::REF_KHZ_2;
        3'h3:    o_ref_clock_khz <= audio_slot_map_pkg::REF_KHZ_3;
        3'h4:    o_ref_clock_khz <= audio_slot_map_pkg::REF_KHZ_4;
        3'h5:    o_ref_clock_khz <= audio_slot_map_pkg::REF_KHZ_5;
        3'h6:    o_ref_clock_khz <= audio_slot_map_pkg::REF_KHZ_6;
        default: o_ref_clock_khz <= audio_slot_map_pkg::REF_KHZ_7;
      endcase
    end
  end

  // Checks
  a_rd_reserved_zero: assert property (@(posedge i_clk) disable iff (!i_nrst)
    (i_ce && i_reg_rd && i_reg_addr == audio_slot_map_pkg::CHAN3_SLOT_SELECT_ADDR)
    |=> o_reg_rdata[7:6] == 2'b00)
    else $error("reserved slot bits read nonzero");
  a_ch2_write_back: assert property (@(posedge i_clk) disable iff (!i_nrst)
    (i_ce && i_reg_wr && i_reg_addr == audio_slot_map_pkg::CHAN2_SLOT_SELECT_ADDR)
    |=> chan_slot_reg[0] == $past(i_reg_wdata[5:0]))
    else $error("channel 2 slot not stored");
  a_ch3_write_back: assert property (@(posedge i_clk) disable iff (!i_nrst)
    (i_ce && i_reg_wr && i_reg_addr == audio_slot_map_pkg::CHAN3_SLOT_SELECT_ADDR)
    |=> chan_slot_reg[1] == $past(i_reg_wdata[5:0]))
    else $error("channel 3 slot not stored");
  a_ch4_write_back: assert property (@(posedge i_clk) disable iff (!i_nrst)
    (i_ce && i_reg_wr && i_reg_addr == audio_slot_map_pkg::CHAN4_SLOT_SELECT_ADDR)
    |=> chan_slot_reg[2] == $past(i_reg_wdata[5:0]))
    else $error("channel 4 slot not stored");
  a_cfg_write_back: assert property (@(posedge i_clk) disable iff (!i_nrst)
    (i_ce && i_reg_wr && i_reg_addr == audio_slot_map_pkg::PORT_MASTER_CONFIG_A_ADDR)
    ##1 (i_ce && i_reg_rd && i_reg_addr == audio_slot_map_pkg::PORT_MASTER_CONFIG_A_ADDR && !i_reg_wr)
    |=> o_reg_rdata == $past(i_reg_wdata, 2))
    else $error("master config readback wrong");
  a_slave_no_drive: assert property (@(posedge i_clk) disable iff (!i_nrst)
    (i_ce && !cfg.master_slave_select) |=> !o_bclk_oe && !o_frame_sync_oe && !o_bclk)
    else $error("slave mode drives clock pins");
  a_gate_holds_low: assert property (@(posedge i_clk) disable iff (!i_nrst)
    (i_ce && cfg.port_clock_gate) |=> !o_bclk && !o_frame_sync)
    else $error("gated clocks still toggle");
  a_custom_follows: assert property (@(posedge i_clk) disable iff (!i_nrst)
    i_ce |=> o_custom_clk_cfg == $past(master_cfg_reg[audio_slot_map_pkg::AUTO_CFG_BIT]))
    else $error("custom clock flag wrong");
  a_ref_top_value: assert property (@(posedge i_clk) disable iff (!i_nrst)
    (i_ce && cfg.ref_clock_freq_select == 3'h7) |=> o_ref_clock_khz == 16'h6000)
    else $error("reference select 7 wrong");
  a_half_talk: assert property (@(posedge i_clk) disable iff (!i_nrst)
    (i_ce && !i_tdm_mode && i_chan_enable[0] && i_cur_right && chan_slot_reg[0] == (i_cur_slot[4:0] + 6'h20))
    |=> o_slot_talk[0])
    else $error("right half slot not matched");
  a_disabled_silent: assert property (@(posedge i_clk) disable iff (!i_nrst)
    (i_ce && !i_chan_enable[1]) |=> !o_slot_talk[1])
    else $error("disabled channel talks");

endmodule

`default_nettype wire

/* verilog/audio_slot_map_pkg.sv */
// Package for the audio slot map configuration block.
// Assumes an 8-bit register port with byte addresses; no other bus is added.
package audio_slot_map_pkg;

  // Register addresses
  localparam logic [7:0] CHAN2_SLOT_SELECT_ADDR    = 8'h0C;
  localparam logic [7:0] CHAN3_SLOT_SELECT_ADDR    = 8'h0D;
  localparam logic [7:0] CHAN4_SLOT_SELECT_ADDR    = 8'h0E;
  localparam logic [7:0] PORT_MASTER_CONFIG_A_ADDR = 8'h13;

  // Reset values
  localparam logic [5:0] CHAN2_SLOT_RESET = 6'h01;
  localparam logic [5:0] CHAN3_SLOT_RESET = 6'h02;
  localparam logic [5:0] CHAN4_SLOT_RESET = 6'h03;
  localparam logic [7:0] MASTER_CFG_RESET = 8'h02;

  // Field positions of the master configuration register, plus the top bit of the slot registers
  localparam int MS_SEL_BIT    = 7;
  localparam int AUTO_CFG_BIT  = 6;
  localparam int PLL_DIS_BIT   = 5;
  localparam int GATE_BIT      = 4;
  localparam int FAMILY_BIT    = 3;
  localparam int REF_SEL_MSB   = 2;
  localparam int SLOT_MSB      = 5;

  // Slot split point between left and right halves
  localparam logic [5:0] RIGHT_HALF_BASE = 6'h20;

  // Reference clock frequencies in kHz, indexed by select value
  localparam logic [15:0] REF_KHZ_0 = 16'h2EE0;
  localparam logic [15:0] REF_KHZ_1 = 16'h3000;
  localparam logic [15:0] REF_KHZ_2 = 16'h32C8;
  localparam logic [15:0] REF_KHZ_3 = 16'h3E80;
  localparam logic [15:0] REF_KHZ_4 = 16'h4B00;
  localparam logic [15:0] REF_KHZ_5 = 16'h4CE0;
  localparam logic [15:0] REF_KHZ_6 = 16'h5DC0;
  localparam logic [15:0] REF_KHZ_7 = 16'h6000;

  // Decoded placement of one channel
  typedef struct packed {
    logic       right_half;
    logic [4:0] half_slot;
    logic [5:0] tdm_slot;
  } slot_place_s;

  // Decoded master configuration
  typedef struct packed {
    logic       master_slave_select;
    logic       auto_cfg_custom;
    logic       auto_pll_disable;
    logic       port_clock_gate;
    logic       rate_family_select;
    logic [2:0] ref_clock_freq_select;
  } master_cfg_s;

endpackage

/* verif/slot_frame_host.sv */
// Far-side model of the serial link: steps through the slots of each frame.
// Assumes one i_clk domain; one slot per clock keeps frames short.
`timescale 1ns/1ps
`default_nettype none
module slot_frame_host (
  // Clock and reset
  input  wire logic       i_clk,
  input  wire logic       i_nrst,
  // Framing mode, 1 for TDM
  input  wire logic       i_tdm_mode,
  // Link timing towards the block
  output logic      [5:0] o_cur_slot,
  output logic            o_cur_right,
  output logic            o_bclk_gen,
  output logic            o_frame_sync_gen
);
  logic [5:0] cnt_reg; // Slot counter, wraps every 64 slots

  // Frame counter; the far side paces the frame in slave mode
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      cnt_reg <= 6'h00;
    end else begin
      cnt_reg <= cnt_reg + 6'h01;
    end
  end

  // Half framing folds the upper 32 slots onto the right half
  assign o_cur_slot  = i_tdm_mode ? cnt_reg : {1'b0, cnt_reg[4:0]};
  assign o_cur_right = cnt_reg[5];
  assign o_bclk_gen  = cnt_reg[0];
  assign o_frame_sync_gen = (cnt_reg == 6'h00);
endmodule
`default_nettype wire

/* verif/tb.sv */
// Self-checking bench for the slot map configuration block.
// Assumes the slot_frame_host model drives the link timing inputs.
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic i_clk = 1'b0, i_nrst = 1'b0, i_ce = 1'b1, i_reg_wr = 1'b0, i_reg_rd = 1'b0, i_tdm_mode = 1'b1;
  logic [7:0] i_reg_addr = 8'h00, i_reg_wdata = 8'h00, o_reg_rdata;
  logic [5:0] i_cur_slot;
  logic [2:0] i_chan_enable = 3'h7, o_slot_talk, tk_exp;
  logic i_cur_right, i_bclk_gen, i_frame_sync_gen, o_bclk, o_bclk_oe, o_frame_sync, o_frame_sync_oe;
  logic o_custom_clk_cfg, o_pll_enable, o_rate_family, rd_seen = 1'b0, tk_ok = 1'b0;
  logic [15:0] o_ref_clock_khz;
  logic [7:0] regs [256];      // Shadow of what each address should read back
  logic [7:0] rdq [$];         // Expected read data, oldest first
  logic [15:0] khz [8] = '{16'h2EE0, 16'h3000, 16'h32C8, 16'h3E80, 16'h4B00, 16'h4CE0, 16'h5DC0, 16'h6000};
  int failures = 0, compares = 0;
  logic [7:0] v;               // Configuration byte under test, driver only
  logic [7:0] slot_v;          // Shadow slot value, watcher only

  always #25 i_clk = ~i_clk;

  audio_slot_map_config u_audio_slot_map_config (.i_clk(i_clk), .i_nrst(i_nrst), .i_ce(i_ce),
    .i_reg_wr(i_reg_wr), .i_reg_rd(i_reg_rd), .i_reg_addr(i_reg_addr), .i_reg_wdata(i_reg_wdata),
    .o_reg_rdata(o_reg_rdata), .i_tdm_mode(i_tdm_mode), .i_cur_slot(i_cur_slot), .i_cur_right(i_cur_right),
    .i_bclk_gen(i_bclk_gen), .i_frame_sync_gen(i_frame_sync_gen), .i_chan_enable(i_chan_enable), .o_bclk(o_bclk),
    .o_bclk_oe(o_bclk_oe), .o_frame_sync(o_frame_sync), .o_frame_sync_oe(o_frame_sync_oe),
    .o_custom_clk_cfg(o_custom_clk_cfg), .o_pll_enable(o_pll_enable), .o_rate_family(o_rate_family),
    .o_ref_clock_khz(o_ref_clock_khz), .o_slot_talk(o_slot_talk));

  slot_frame_host u_slot_frame_host (.i_clk(i_clk), .i_nrst(i_nrst), .i_tdm_mode(i_tdm_mode),
    .o_cur_slot(i_cur_slot), .o_cur_right(i_cur_right), .o_bclk_gen(i_bclk_gen), .o_frame_sync_gen(i_frame_sync_gen));

  // Single comparison point for every check
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    compares++;
    if (seen !== exp) begin
      failures++;
      $display("Error at %0t ns: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // Verdict and end of run
  task automatic summarize();
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  // One bus cycle; every field is set at once so nothing is assigned twice per step
  task automatic bus(input logic wr, input logic rd, input logic [7:0] a, input logic [7:0] d);
    i_reg_wr = wr;
    i_reg_rd = rd;
    i_reg_addr = a;
    i_reg_wdata = d;
    if (rd) rdq.push_back(regs[a]);
    @(posedge i_clk);
    #2;
  endtask

  // Reset, then read every mapped register plus one unmapped hole
  task automatic reset_and_read(input int n);
    i_nrst = 1'b0;
    repeat (n) @(posedge i_clk);
    #2;
    i_nrst = 1'b1;
    foreach (regs[a]) if (a inside {8'h0C, 8'h0D, 8'h0E, 8'h13, 8'h0F}) bus(0, 1, 8'(a), 8'h00);
    bus(0, 0, 8'h00, 8'h00);
  endtask

  // Watcher: keeps the shadow, predicts talk one cycle ahead, retires read notes
  always @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      foreach (regs[a]) regs[a] = 8'h00;
      regs[8'h0C] = 8'h01;
      regs[8'h0D] = 8'h02;
      regs[8'h0E] = 8'h03;
      regs[8'h13] = 8'h02;
      rdq.delete();
      rd_seen = 1'b0;
      tk_ok = 1'b0;
    end else if (!i_ce) begin
      tk_ok = 1'b0; // Frozen state, no prediction across it
    end else begin
      if (rd_seen) check(o_reg_rdata, rdq.pop_front());
      if (tk_ok) check(o_slot_talk, tk_exp);
      for (int c = 0; c < 3; c++) begin
        slot_v = regs[8'h0C + c];
        tk_exp[c] = i_chan_enable[c] && (i_tdm_mode ? (i_cur_slot == slot_v[5:0])
                    : (i_cur_right == slot_v[5] && i_cur_slot[4:0] == slot_v[4:0]));
      end
      tk_ok = 1'b1;
      if (i_reg_wr && i_reg_addr inside {8'h0C, 8'h0D, 8'h0E}) regs[i_reg_addr] = i_reg_wdata & 8'h3F;
      if (i_reg_wr && i_reg_addr == 8'h13) regs[i_reg_addr] = i_reg_wdata;
      rd_seen = i_reg_rd;
    end
  end

  // Watchdog reckoned at about fifty times the expected run
  initial begin
    #(50 * 20000);
    failures++;
    summarize();
  end

  initial begin
    void'($urandom(32'h9357));
    reset_and_read(20);
    // Random slot numbers in both framings; software keeps reserved bits at zero
    for (int m = 0; m < 4; m++) begin
      i_tdm_mode = m[0];
      // Channel 2 always enabled in half framing so its right-half slot is exercised
      i_chan_enable = 3'($urandom) | {2'b00, !m[0]};
      for (int c = 0; c < 3; c++) bus(1, 0, 8'h0C + 8'(c), {2'b00, 6'($urandom)});
      for (int c = 0; c < 3; c++) bus(0, 1, 8'h0C + 8'(c), 8'h00);
      bus(1, 0, 8'h0C, 8'h3F);
      repeat (70) bus(0, 0, 8'h00, 8'h00);
    end
    // Writes with the clock enable low are lost
    i_ce = 1'b0;
    bus(1, 0, 8'h0D, 8'h2A);
    i_ce = 1'b1;
    bus(0, 1, 8'h0D, 8'h00);
    // Master configuration: all eight reference selects, gating in master mode
    for (int r = 0; r < 8; r++) begin
      // Master and gate bits walk all four combinations
      v = {r[0], 2'($urandom), r[1], 1'($urandom), 3'(r)};
      bus(1, 0, 8'h13, v);
      bus(0, 1, 8'h13, 8'h00);
      repeat (5) bus(0, 0, 8'h00, 8'h00);
      check(o_ref_clock_khz, khz[r]);
      check(o_custom_clk_cfg, v[6]);
      check(o_pll_enable, 1'(v[6] | ~v[5]));
      check(o_rate_family, v[3]);
      check({o_bclk_oe, o_frame_sync_oe}, {2{v[7]}});
      // Pins lag the generated waveforms by three edges; the model counts one slot per clock in TDM
      check({o_bclk, o_frame_sync}, (v[7] && !v[4]) ? {~i_bclk_gen, i_cur_slot == 6'h03} : 2'b00);
    end
    reset_and_read(3);
    // Derived clock outputs back at their reset values
    check({o_custom_clk_cfg, o_pll_enable, o_rate_family, o_bclk_oe}, 4'h4);
    check(o_ref_clock_khz, khz[2]);
    summarize();
  end
endmodule
`default_nettype wire
